// ### core/otct_defines.svh
/*
  Constants of the oscillator trim compensation block: timing,
  register indices, field positions and reset values.
  Assumes inclusion by otct_pkg, the design file and the checker.
*/
`ifndef OTCT_DEFINES_SVH
`define OTCT_DEFINES_SVH

// timing
`define OTCT_CLK_KHZ        64'd250000
`define OTCT_CONV_TIME_US   64'd22000
`define OTCT_SHORT_PERIOD_S 64'd60
`define OTCT_LONG_PERIOD_S  64'd600
`define OTCT_CNT_W          40

// register indices, byte address is four times the index
`define OTCT_ADDR_W    12
`define OTCT_IDX_CURV  10'h00C
`define OTCT_IDX_CTRL  10'h00D
`define OTCT_IDX_FAT   10'h00E
`define OTCT_IDX_FDT   10'h00F
`define OTCT_IDX_INIT  10'h040
`define OTCT_IDX_STAT  10'h041

// control fields
`define OTCT_CTRL_TSE  7
`define OTCT_CTRL_BACKUP_SENSE_ENABLE 6
`define OTCT_CTRL_BACKUP_SENSE_PERIOD_SEL 5
`define OTCT_INIT_DT_LSB 8
`define OTCT_STAT_BUSY 16

// responses
`define OTCT_RESP_OKAY   2'h0
`define OTCT_RESP_SLVERR 2'h2

// trim arithmetic
`define OTCT_GAIN_UNITY   6'h10
`define OTCT_GAIN_DN_MAX  5'h08
`define OTCT_GAIN_UP_BASE 5'h10
`define OTCT_GAIN_SHIFT   4
`define OTCT_ALPHA_SHIFT  11
`define OTCT_AT_MAX_CODE  6'h3F
`define OTCT_DT_SIGN      4
`define OTCT_DT_MAG_MAX   4'hA
`define OTCT_TURNOVER_C   11'h019

// reset values
`define OTCT_INIT_AT_RST  6'h20
`define OTCT_INIT_DT_RST  5'h00

`endif

// ### core/otct_pkg.sv
/*
  Types of the oscillator trim compensation block: bus carriers,
  sequencer phases and the block's single state record.
  Assumes otct_defines.svh on the include path.
*/
`include "otct_defines.svh"

package otct_pkg;

  typedef enum logic [1:0] {
    OTCT_IDLE  = 2'b00,
    OTCT_CONV1 = 2'b01,
    OTCT_CONV2 = 2'b10,
    OTCT_APPLY = 2'b11
  } otct_phase_t;

  typedef struct packed {
    logic                    awvalid;
    logic [`OTCT_ADDR_W-1:0] awaddr;
    logic                    wvalid;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bready;
    logic                    arvalid;
    logic [`OTCT_ADDR_W-1:0] araddr;
    logic                    rready;
  } otct_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } otct_axi_rsp_t;

  typedef struct packed {
    otct_phase_t            phase;
    logic [`OTCT_CNT_W-1:0] conv_cnt;
    logic [`OTCT_CNT_W-1:0] period_cnt;
    logic [9:0]             samp1;
    logic [9:0]             temp_avg;
    logic [5:0]             fat;
    logic [4:0]             fdt;
    logic                   temp_sense_enable;
    logic                   backup_sense_enable;
    logic                   backup_sense_period_sel;
    logic                   tse_prev;
    logic [5:0]             init_at;
    logic [4:0]             init_dt;
    logic [4:0]             gain;
    logic [7:0]             curv;
    logic                   loaded;
    logic                   busy;
    logic                   aw_have;
    logic [9:0]             aw_idx;
    logic                   w_have;
    logic [15:0]            wdata;
    logic [1:0]             wstrb;
    otct_axi_rsp_t          rsp;
  } otct_state_t;

endpackage

// ### core/otct_trim.sv
/*
  Oscillator temperature-compensation trim logic with an AXI4-Lite
  register slave. Schedules paired temperature conversions, scales
  the curvature correction by the factory gain and reports final
  analog and digital trim codes.
  Assumes the sensor front end delivers a signed reading on
  temp_in whenever sensor_on_out is high, that supply status
  inputs are synchronous, and that reset models first power-up.
*/
// Summary of operation
// - backup period ten minutes, or one when selected
// - backup sensing disabled means no backup conversions
// - every conversion lasts 22 ms in both modes
// - gain field five bits, codes 00000 to 11111
// - gain code maps to multiplier 0.5 to 2.0
// - gain loaded once at power-up, never writable
// - final analog trim bits 5:0, rest zero, read-only
// - final analog trim refreshed after every correction
// - final digital trim bits 4:0, rest zero, read-only
// - final digital trim refreshed after every correction
// - digital trim sign bit plus magnitude 0 to 10
// - backup sensing inhibited while backup supply is low
// - sensing off on main supply means initial trims drive frequency
// - enabling sensing averages two conversions
// - analog code 000000 +32 down to 111111 -31
`timescale 1ns/1ns
`include "otct_defines.svh"

module otct_trim #(
  parameter logic [`OTCT_CNT_W-1:0] CONV_CYC =
    `OTCT_CNT_W'(`OTCT_CONV_TIME_US * `OTCT_CLK_KHZ / 64'd1000),
  parameter logic [`OTCT_CNT_W-1:0] SHORT_CYC =
    `OTCT_CNT_W'(`OTCT_SHORT_PERIOD_S * `OTCT_CLK_KHZ * 64'd1000),
  parameter logic [`OTCT_CNT_W-1:0] LONG_CYC =
    `OTCT_CNT_W'(`OTCT_LONG_PERIOD_S * `OTCT_CLK_KHZ * 64'd1000)
) (
  // clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_n_in,
  // register bus
  input  wire otct_pkg::otct_axi_req_t axi_req_in,
  output      otct_pkg::otct_axi_rsp_t axi_rsp_out,
  // supply status
  input  wire logic                    on_backup_in,
  input  wire logic                    backup_ok_in,
  // factory values
  input  wire logic [4:0]              factory_gain_in,
  input  wire logic [7:0]              factory_curv_in,
  // sensor front end
  input  wire logic [9:0]              temp_in,
  output      logic                    sensor_on_out,
  // trim codes in use
  output      logic [5:0]              final_analog_trim_out,
  output      logic [4:0]              final_digital_trim_out
);

  otct_pkg::otct_state_t q;
  otct_pkg::otct_state_t d;

  ////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  // multiplier in sixteenths; codes 9..15 carry no meaning, unity
  function automatic logic [5:0] gain_mult(input logic [4:0] c);
    logic [5:0] m;
    m = `OTCT_GAIN_UNITY;
    if (c != 5'h00 && c <= `OTCT_GAIN_DN_MAX) begin
      m = `OTCT_GAIN_UNITY - {1'b0, c};
    end else if (c >= `OTCT_GAIN_UP_BASE) begin
      m = {1'b0, c} + 6'h01;
    end
    return m;
  endfunction

  // magnitudes above ten are not defined, so they are clamped
  function automatic logic [4:0] dt_clean(input logic [4:0] c);
    logic [4:0] r;
    r = c;
    if (c[3:0] > `OTCT_DT_MAG_MAX) begin
      r = {c[`OTCT_DT_SIGN], `OTCT_DT_MAG_MAX};
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_mux(
    input otct_pkg::otct_state_t s,
    input logic [9:0]            idx
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      `OTCT_IDX_CURV: v[7:0] = s.curv;
      `OTCT_IDX_CTRL: begin
        v[`OTCT_CTRL_TSE]  = s.temp_sense_enable;
        v[`OTCT_CTRL_BACKUP_SENSE_ENABLE] = s.backup_sense_enable;
        v[`OTCT_CTRL_BACKUP_SENSE_PERIOD_SEL] = s.backup_sense_period_sel;
        v[4:0]             = s.gain;
      end
      `OTCT_IDX_FAT: v[5:0] = s.fat;
      `OTCT_IDX_FDT: v[4:0] = s.fdt;
      `OTCT_IDX_INIT: begin
        v[5:0] = s.init_at;
        v[`OTCT_INIT_DT_LSB+:5] = s.init_dt;
      end
      `OTCT_IDX_STAT: begin
        v[9:0] = s.temp_avg;
        v[`OTCT_STAT_BUSY] = s.busy;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // unmapped indices answer with an error response
  function automatic logic mapped(input logic [9:0] idx);
    logic m;
    case (idx)
      `OTCT_IDX_CURV,
      `OTCT_IDX_CTRL,
      `OTCT_IDX_FAT,
      `OTCT_IDX_FDT,
      `OTCT_IDX_INIT,
      `OTCT_IDX_STAT: m = 1'b1;
      default:        m = 1'b0;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // correction datapath

  logic signed [10:0] avg_sum;
  logic signed [10:0] dtemp;
  logic        [9:0]  dmag;
  logic        [19:0] sq;
  logic        [27:0] ppm_raw;
  logic        [16:0] ppm;
  logic        [22:0] steps_raw;
  logic        [5:0]  steps;
  logic        [5:0]  fat_new;

  always_comb begin
    avg_sum = $signed({q.samp1[9], q.samp1}) +
              $signed({temp_in[9], temp_in});
    dtemp   = $signed({q.temp_avg[9], q.temp_avg}) -
              $signed(`OTCT_TURNOVER_C);
    dmag    = dtemp[10] ? 10'(-dtemp) : dtemp[9:0];
    sq      = dmag * dmag;
    // curvature holds |alpha| scaled by 2048
    ppm_raw = sq * q.curv;
    ppm     = ppm_raw[`OTCT_ALPHA_SHIFT+:17];
    steps_raw = ppm * gain_mult(q.gain);
    // far from turnover the code saturates rather than wrapping
    steps   = (steps_raw[22:`OTCT_GAIN_SHIFT] >
               19'(`OTCT_AT_MAX_CODE)) ?
              `OTCT_AT_MAX_CODE : steps_raw[9:4];
    // lower codes mean more positive trim, so add by subtracting
    fat_new = (steps >= q.init_at) ? 6'h00 :
              q.init_at - steps;
  end

  ////////////////////////////////////////////////////////////////////
  // scheduling terms

  logic                   sense_main;
  logic                   sense_bak;
  logic                   sense_ok;
  logic                   tse_rise;
  logic [`OTCT_CNT_W-1:0] period_last;

  always_comb begin
    sense_main  = !on_backup_in && q.temp_sense_enable;
    sense_bak   = on_backup_in && q.backup_sense_enable && backup_ok_in;
    sense_ok    = sense_main || sense_bak;
    tse_rise    = q.temp_sense_enable && !q.tse_prev;
    period_last = (on_backup_in && !q.backup_sense_period_sel) ?
                  LONG_CYC - `OTCT_CNT_W'(1) :
                  SHORT_CYC - `OTCT_CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////
  // bus handshake terms

  logic       aw_take;
  logic       w_take;
  logic       wr_fire;
  logic       b_done;
  logic       ar_take;
  logic       r_done;
  logic [9:0] rd_idx;

  always_comb begin
    aw_take = q.rsp.awready && axi_req_in.awvalid;
    w_take  = q.rsp.wready && axi_req_in.wvalid;
    // a new response waits until the old one has been taken
    wr_fire = q.aw_have && q.w_have && !q.rsp.bvalid;
    b_done  = q.rsp.bvalid && axi_req_in.bready;
    ar_take = q.rsp.arready && axi_req_in.arvalid;
    r_done  = q.rsp.rvalid && axi_req_in.rready;
    rd_idx  = axi_req_in.araddr[`OTCT_ADDR_W-1:2];
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.tse_prev = q.temp_sense_enable;

    // factory values are caught once after power-up only
    if (!q.loaded) begin
      d.gain   = factory_gain_in;
      d.curv   = factory_curv_in;
      d.loaded = 1'b1;
    end

    // period timer
    // held at reload while barred, so the first period is whole
    if (!sense_ok || tse_rise || q.period_cnt > period_last) begin
      d.period_cnt = period_last;
    end else if (q.period_cnt != `OTCT_CNT_W'(0)) begin
      d.period_cnt = q.period_cnt - `OTCT_CNT_W'(1);
    end

    case (q.phase)
      otct_pkg::OTCT_IDLE: begin
        if (sense_ok && (tse_rise && !on_backup_in ||
            q.period_cnt == `OTCT_CNT_W'(0))) begin
          d.phase      = otct_pkg::OTCT_CONV1;
          d.conv_cnt   = CONV_CYC - `OTCT_CNT_W'(1);
          d.busy       = 1'b1;
          d.period_cnt = period_last;
        end
      end
      otct_pkg::OTCT_CONV1, otct_pkg::OTCT_CONV2: begin
        if (!sense_ok) begin
          // supply loss or disable drops the cycle unapplied
          d.phase = otct_pkg::OTCT_IDLE;
          d.busy  = 1'b0;
        end else if (q.conv_cnt != `OTCT_CNT_W'(0)) begin
          d.conv_cnt = q.conv_cnt - `OTCT_CNT_W'(1);
        end else if (q.phase == otct_pkg::OTCT_CONV1) begin
          d.samp1    = temp_in;
          d.conv_cnt = CONV_CYC - `OTCT_CNT_W'(1);
          d.phase    = otct_pkg::OTCT_CONV2;
        end else begin
          d.temp_avg = avg_sum[10:1];
          d.busy     = 1'b0;
          d.phase    = otct_pkg::OTCT_APPLY;
        end
      end
      otct_pkg::OTCT_APPLY: begin
        d.fat   = fat_new;
        d.fdt   = dt_clean(q.init_dt);
        d.phase = otct_pkg::OTCT_IDLE;
      end
      default: d.phase = otct_pkg::OTCT_IDLE;
    endcase

    // with sensing off on the main supply the initial trims act directly
    if (!on_backup_in && !q.temp_sense_enable) begin
      d.fat = q.init_at;
      d.fdt = dt_clean(q.init_dt);
    end

    // write channels, taken in either order
    if (aw_take) begin
      d.aw_have = 1'b1;
      d.aw_idx  = axi_req_in.awaddr[`OTCT_ADDR_W-1:2];
    end
    if (w_take) begin
      d.w_have = 1'b1;
      d.wdata  = axi_req_in.wdata[15:0];
      d.wstrb  = axi_req_in.wstrb[1:0];
    end
    if (wr_fire) begin
      d.aw_have   = 1'b0;
      d.w_have    = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = mapped(q.aw_idx) ? `OTCT_RESP_OKAY :
                    `OTCT_RESP_SLVERR;
      // trim monitors and gain bits ignore writes
      if (q.aw_idx == `OTCT_IDX_CTRL && q.wstrb[0]) begin
        d.temp_sense_enable  = q.wdata[`OTCT_CTRL_TSE];
        d.backup_sense_enable = q.wdata[`OTCT_CTRL_BACKUP_SENSE_ENABLE];
        d.backup_sense_period_sel = q.wdata[`OTCT_CTRL_BACKUP_SENSE_PERIOD_SEL];
      end
      if (q.aw_idx == `OTCT_IDX_INIT) begin
        if (q.wstrb[0]) begin
          d.init_at = q.wdata[5:0];
        end
        if (q.wstrb[1]) begin
          d.init_dt = q.wdata[`OTCT_INIT_DT_LSB+:5];
        end
      end
    end
    if (b_done) begin
      d.rsp.bvalid = 1'b0;
    end
    // one write outstanding: each ready only while its own channel holds nothing and no response is pending
    d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
    d.rsp.wready  = !d.w_have && !d.rsp.bvalid;

    // read channel
    if (r_done) begin
      d.rsp.rvalid = 1'b0;
    end
    // read data is taken from the state at the address handshake
    if (ar_take) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata  = rd_mux(q, rd_idx);
      d.rsp.rresp  = mapped(rd_idx) ?
                     `OTCT_RESP_OKAY : `OTCT_RESP_SLVERR;
    end
    d.rsp.arready = !d.rsp.rvalid;
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q         <= '0;
      q.phase   <= otct_pkg::OTCT_IDLE;
      q.init_at <= `OTCT_INIT_AT_RST;
      q.init_dt <= `OTCT_INIT_DT_RST;
      // finals start on the initial trim reset values
      q.fat     <= `OTCT_INIT_AT_RST;
      q.fdt     <= `OTCT_INIT_DT_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign axi_rsp_out            = q.rsp;
  assign sensor_on_out          = q.busy;
  assign final_analog_trim_out  = q.fat;
  assign final_digital_trim_out = q.fdt;

endmodule

// ### tb/otct_checker.sv
/*
  Port assertions for the oscillator trim compensation block.
  Assumes it is bound to every otct_trim instance.
*/
`timescale 1ns/1ns
`include "otct_defines.svh"
module otct_checker #(
  parameter logic [`OTCT_CNT_W-1:0] CONV_CYC = 20
) (
  // clock and reset
  input wire logic                    ref_clk_in,
  input wire logic                    rst_n_in,
  // register bus
  input wire otct_pkg::otct_axi_req_t axi_req_in,
  input wire otct_pkg::otct_axi_rsp_t axi_rsp_out,
  // supply, sensor and trims
  input wire logic                    on_backup_in,
  input wire logic                    backup_ok_in,
  input wire logic                    sensor_on_out,
  input wire logic [5:0]              final_analog_trim_out,
  input wire logic [4:0]              final_digital_trim_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // length of the current sensor run
  logic [`OTCT_CNT_W-1:0] on_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in) on_q <= '0;
    else on_q <= sensor_on_out ? on_q + 1'b1 : '0;

  ////////////////////////////////////////////////////////////////////////
  conv_len_a: assert property (on_q <= 2 * CONV_CYC)
    else $error("sensor run too long");
  conv_full_a: assert property ($fell(sensor_on_out) && !on_backup_in
    |-> on_q == 2 * CONV_CYC) else $error("main run not two conversions");
  bk_allow_a: assert property ($rose(sensor_on_out) && on_backup_in
    |-> $past(backup_ok_in)) else $error("backup run on low supply");
  bk_abort_a: assert property (sensor_on_out && on_backup_in
    && !backup_ok_in |-> ##[1:2] !sensor_on_out)
    else $error("run not aborted on low supply");
  fin_hold_a: assert property (sensor_on_out && $past(sensor_on_out)
    |-> $stable(final_analog_trim_out) && $stable(final_digital_trim_out))
    else $error("trim changed mid run");
  dt_range_a: assert property (final_digital_trim_out[3:0] <= 4'hA)
    else $error("digital magnitude above ten");
  rd_lat_a: assert property (axi_req_in.arvalid && axi_rsp_out.arready
    |=> axi_rsp_out.rvalid) else $error("read answer late");
  rd_hold_a: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
    |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read data dropped");
  wr_lat_a: assert property (axi_req_in.awvalid && axi_rsp_out.awready
    && axi_req_in.wvalid && axi_rsp_out.wready |-> ##2 axi_rsp_out.bvalid)
    else $error("write answer late");
  b_hold_a: assert property (axi_rsp_out.bvalid && !axi_req_in.bready
    |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write response dropped");
endmodule

bind otct_trim otct_checker #(.CONV_CYC(CONV_CYC)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out),
  .on_backup_in(on_backup_in), .backup_ok_in(backup_ok_in),
  .sensor_on_out(sensor_on_out),
  .final_analog_trim_out(final_analog_trim_out),
  .final_digital_trim_out(final_digital_trim_out));

// ### tb/otct_trim_tb.sv
/*
  Self-checking bench for the oscillator trim compensation block.
  Assumes the design package and the bound checker are compiled.
*/
`timescale 1ns/1ns
module otct_trim_tb;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } otct_exp_t;
  localparam logic [4:0] GL [4] = '{5'h00, 5'h08, 5'h10, 5'h1F};
  logic                    ref_clk, rst_n, on_backup, backup_ok, sensor_on;
  logic [4:0]              gain, fdt, g, dt, fd;
  logic [5:0]              fat, at;
  logic [7:0]              curv;
  logic [9:0]              temp;
  otct_pkg::otct_axi_req_t req;
  otct_pkg::otct_axi_rsp_t rsp;
  otct_exp_t               q[$];
  otct_exp_t               e;
  int                      error_cnt, check_count, seed, tmp, n;

  otct_trim #(.CONV_CYC(40'd20), .SHORT_CYC(40'd200), .LONG_CYC(40'd2000))
  DUT (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .axi_req_in(req),
    .axi_rsp_out(rsp), .on_backup_in(on_backup), .backup_ok_in(backup_ok),
    .factory_gain_in(gain), .factory_curv_in(curv), .temp_in(temp),
    .sensor_on_out(sensor_on), .final_analog_trim_out(fat),
    .final_digital_trim_out(fdt));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back('{32'h0, 32'h0, r});
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    q.push_back('{d, m, r});
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
  endtask

  // cycles until the sensor next starts, capped at 3000
  task automatic next_rise(output int c);
    c = 0;
    while (sensor_on === 1'b1 && c < 3000) begin
      @(posedge ref_clk);
      c++;
    end
    while (sensor_on !== 1'b1 && c < 3000) begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  function automatic logic [5:0] exp_fat(input int a, gc, c, t);
    int mult, corr;
    mult = (gc == 0) ? 16 : (gc <= 8) ? 16 - gc : (gc >= 16) ? gc + 1 : 16;
    corr = ((((t - 25) * (t - 25) * c) >>> 11) * mult) >>> 4;
    if (corr > 63) corr = 63;
    return (a > corr) ? 6'(a - corr) : 6'h00;
  endfunction

  // response monitor: every answer consumes the oldest note
  always @(posedge ref_clk) begin
    if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
      e = q.pop_front();
      check(rsp.rvalid ? rsp.rdata & e.m : 32'h0, e.d);
      check({30'h0, rsp.rvalid ? rsp.rresp : rsp.bresp}, {30'h0, e.r});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32;
    req = '0;
    rst_n = 1'b0;
    on_backup = 1'b0;
    backup_ok = 1'b1;
    gain = 5'h00;
    curv = 8'h00;
    temp = 10'h000;
    for (int i = 0; i < 5; i++) begin
      g = (i < 4) ? GL[i] : 5'($random(seed));
      rst_n <= 1'b0;
      gain <= g;
      curv <= 8'($random(seed));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check({26'h0, fat}, 32'h20);
      rd(12'h030, {24'h0, curv}, 32'hFFFFFFFF, 2'h0);
      rd(12'h038, 32'h20, 32'hFFFFFFFF, 2'h0);
      rd(12'h03C, 32'h0, 32'hFFFFFFFF, 2'h0);
      wr(12'h034, 32'h1F, 2'h0);
      wr(12'h038, 32'hFF, 2'h0);
      wr(12'h03C, 32'hFF, 2'h0);
      rd(12'h034, {27'h0, g}, 32'hFFFFFFFF, 2'h0);
      rd(12'h200, 32'h0, 32'hFFFFFFFF, 2'h2);
      at = 6'($random(seed));
      dt = 5'($random(seed));
      fd = {dt[4], (dt[3:0] > 4'hA) ? 4'hA : dt[3:0]};
      wr(12'h100, {19'h0, dt, 2'h0, at}, 2'h0);
      rd(12'h038, {26'h0, at}, 32'hFFFFFFFF, 2'h0);
      rd(12'h03C, {27'h0, fd}, 32'hFFFFFFFF, 2'h0);
      tmp = 5 + ($random(seed) & 31);
      temp <= 10'(tmp);
      wr(12'h034, 32'h80, 2'h0);
      next_rise(n);
      next_rise(n);
      repeat (2) @(posedge ref_clk);
      rd(12'h038, {26'h0, exp_fat(at, g, curv, tmp)}, 32'hFF, 2'h0);
      rd(12'h03C, {27'h0, fd}, 32'hFF, 2'h0);
      check({26'h0, fat}, {26'h0, exp_fat(at, g, curv, tmp)});
      check({27'h0, fdt}, {27'h0, fd});
      // the next periodic run is already under way here
      rd(12'h104, {15'h0, 1'b1, 6'h0, temp}, 32'h103FF, 2'h0);
    end
    on_backup <= 1'b1;
    wr(12'h034, 32'h20, 2'h0);
    next_rise(n);
    check(32'(n >= 3000), 32'h1);
    wr(12'h034, 32'h60, 2'h0);
    next_rise(n);
    next_rise(n);
    check(32'(n >= 199 && n <= 201), 32'h1);
    wr(12'h034, 32'h40, 2'h0);
    next_rise(n);
    next_rise(n);
    check(32'(n >= 1999 && n <= 2001), 32'h1);
    backup_ok <= 1'b0;
    next_rise(n);
    check(32'(n >= 3000), 32'h1);
    results();
  end

  // hang guard: well beyond the longest expected run
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
endmodule
